// ==== hdl/tie_pkg.sv ====
// constants and carrier types for the trap and interrupt entry block
package tie_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CMD      = 8'h04;
  localparam logic [7:0] OFF_ENTRY    = 8'h08;
  localparam logic [7:0] OFF_ARG0_LO  = 8'h0C;
  localparam logic [7:0] OFF_ARG0_HI  = 8'h10;
  localparam logic [7:0] OFF_ARG1_LO  = 8'h14;
  localparam logic [7:0] OFF_ARG1_HI  = 8'h18;
  localparam logic [7:0] OFF_ARG2_LO  = 8'h1C;
  localparam logic [7:0] OFF_ARG2_HI  = 8'h20;
  localparam logic [7:0] OFF_SUMMARY  = 8'h24;
  localparam logic [7:0] OFF_MASK_LO  = 8'h28;
  localparam logic [7:0] OFF_MASK_HI  = 8'h2C;
  localparam logic [7:0] OFF_PC_LO    = 8'h30;
  localparam logic [7:0] OFF_PC_HI    = 8'h34;
  localparam logic [7:0] OFF_HALT     = 8'h38;
  localparam logic [7:0] OFF_PENDING  = 8'h3C;
  // ---------------------------------------------------------------
  // status word layout and reset
  // ---------------------------------------------------------------
  localparam int          SW_MODE_BIT = 3;
  localparam logic        MODE_KERNEL = 1'b0;
  localparam logic        MODE_USER   = 1'b1;
  localparam logic [3:0]  SW_RESET    = 4'h7;
  // priority levels per source
  localparam logic [2:0]  LVL_IPI     = 3'h5;
  localparam logic [2:0]  LVL_CLOCK   = 3'h5;
  localparam logic [2:0]  LVL_PERF    = 3'h6;
  localparam logic [2:0]  LVL_MCHK    = 3'h7;
  // summary flag positions
  localparam int BIT_INV = 1;
  localparam int BIT_DZE = 2;
  localparam int BIT_OVF = 3;
  localparam int BIT_UNF = 4;
  localparam int BIT_INE = 5;
  localparam int BIT_IOV = 6;
  localparam int FP_REG_BASE = 32;
  // software command codes (written to OFF_CMD)
  localparam logic [1:0] CMD_RET_TRAP = 2'h1;
  localparam logic [1:0] CMD_RET_SYS  = 2'h2;
  localparam logic [1:0] CMD_SWAP_LVL = 2'h3;

  typedef enum logic [2:0] {
    ENT_NONE  = 3'h0,
    ENT_ARITH = 3'h1,
    ENT_INSTR = 3'h2,
    ENT_INTR  = 3'h3,
    ENT_MEM   = 3'h4,
    ENT_SYS   = 3'h5,
    ENT_UNA   = 3'h6,
    ENT_HALT  = 3'h7
  } tie_entry_t;

  typedef enum logic [1:0] {
    HALT_NONE  = 2'h0,
    HALT_DMCHK = 2'h1,
    HALT_KSTK  = 2'h2
  } tie_halt_t;

  // fault requests from the pipeline, one-cycle pulses
  typedef struct packed {
    logic        arith;       // arithmetic trap completes
    logic [6:0]  arith_flags; // bit positions as summary register
    logic        dest_fp;
    logic [4:0]  dest_reg;
    logic        instr;
    logic [2:0]  instr_code;
    logic        mem;
    logic [2:0]  mem_code;
    logic [1:0]  mem_kind;    // 0 load, 1 store, 2 fetch
    logic        sys;
    logic        una;
    logic [31:0] una_instr;
    logic [63:0] vaddr;
    logic [63:0] pc;          // address of the faulting/trapping instr
    logic        stack_fault;
    logic [63:0] ksp;
  } tie_fault_t;

  // interrupt request levels from the platform
  typedef struct packed {
    logic        ipi;
    logic        clock;
    logic        mchk;
    logic        dev;
    logic [2:0]  dev_level;
    logic        perf;
    logic [63:0] vector;
    logic [63:0] logout_addr;
    logic        mchk_busy;   // first logout longword non-zero
  } tie_irq_t;
endpackage : tie_pkg

// ==== hdl/tie_core.sv ====
// trap and interrupt entry logic with an axi4-lite register slave
`timescale 1ns/1ps
module tie_core (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire tie_pkg::tie_fault_t i_fault,
  input  wire tie_pkg::tie_irq_t   i_irq,
  output logic                   o_entry_valid,
  output tie_pkg::tie_entry_t    o_entry,
  output logic [3:0]             o_status_word,
  output logic                   o_halt,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]          sw;
    logic [3:0]          saved_sw;
    tie_pkg::tie_entry_t entry;
    logic                entry_valid;
    logic [63:0]         a0;
    logic [63:0]         a1;
    logic [63:0]         a2;
    logic [63:0]         saved_pc;
    logic [6:0]          summary;
    logic [63:0]         wmask;
    tie_pkg::tie_halt_t  halt;
    logic                aw_got;
    logic [7:0]          aw_addr;
    logic                w_got;
    logic [31:0]         w_data;
    logic                w_lane0;
    logic                bvalid;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [1:0]          bresp;
  } tie_state_t;

  tie_state_t st_reg;
  tie_state_t st_next;

  function automatic logic [3:0] legal_sw(input logic [3:0] v);
    // user mode cannot carry a level
    legal_sw = v[tie_pkg::SW_MODE_BIT] ? {tie_pkg::MODE_USER, 3'h0} : v;
  endfunction : legal_sw

  function automatic logic [31:0] pick(input logic [63:0] v, input logic hi);
    pick = hi ? v[63:32] : v[31:0];
  endfunction : pick

  // ---------------------------------------------------------------
  // interrupt arbitration
  // ---------------------------------------------------------------
  logic [2:0] cur_lvl;
  logic       irq_go;
  logic [2:0] irq_code;
  logic [2:0] irq_lvl;

  always_comb begin
    cur_lvl  = st_reg.sw[2:0];
    irq_go   = 1'b0;
    irq_code = 3'h0;
    irq_lvl  = 3'h0;
    // fixed order mchk, perf, dev at level 6 or above, ipi, clock, other dev; anything not above current level stays pending
    if (i_irq.mchk && tie_pkg::LVL_MCHK > cur_lvl) begin
      irq_go = 1'b1; irq_code = 3'h2; irq_lvl = tie_pkg::LVL_MCHK;
    end else if (i_irq.perf && tie_pkg::LVL_PERF > cur_lvl) begin
      irq_go = 1'b1; irq_code = 3'h4; irq_lvl = tie_pkg::LVL_PERF;
    end else if (i_irq.dev && i_irq.dev_level > cur_lvl
                 && i_irq.dev_level >= tie_pkg::LVL_PERF) begin
      irq_go = 1'b1; irq_code = 3'h3; irq_lvl = i_irq.dev_level;
    end else if (i_irq.ipi && tie_pkg::LVL_IPI > cur_lvl) begin
      irq_go = 1'b1; irq_code = 3'h0; irq_lvl = tie_pkg::LVL_IPI;
    end else if (i_irq.clock && tie_pkg::LVL_CLOCK > cur_lvl) begin
      irq_go = 1'b1; irq_code = 3'h1; irq_lvl = tie_pkg::LVL_CLOCK;
    end else if (i_irq.dev && i_irq.dev_level > cur_lvl) begin
      irq_go = 1'b1; irq_code = 3'h3; irq_lvl = i_irq.dev_level;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;

  always_comb begin
    wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    rd_fire = s_axi_arvalid && !st_reg.rvalid;
    rd_ok   = 1'b1;
    rd_val  = 32'h0000_0000;
    unique case (s_axi_araddr)
      tie_pkg::OFF_STATUS:  rd_val = {28'h0, st_reg.sw};
      tie_pkg::OFF_ENTRY:   rd_val = {29'h0, st_reg.entry};
      tie_pkg::OFF_ARG0_LO: rd_val = pick(st_reg.a0, 1'b0);
      tie_pkg::OFF_ARG0_HI: rd_val = pick(st_reg.a0, 1'b1);
      tie_pkg::OFF_ARG1_LO: rd_val = pick(st_reg.a1, 1'b0);
      tie_pkg::OFF_ARG1_HI: rd_val = pick(st_reg.a1, 1'b1);
      tie_pkg::OFF_ARG2_LO: rd_val = pick(st_reg.a2, 1'b0);
      tie_pkg::OFF_ARG2_HI: rd_val = pick(st_reg.a2, 1'b1);
      tie_pkg::OFF_SUMMARY: rd_val = {25'h0, st_reg.summary};
      tie_pkg::OFF_MASK_LO: rd_val = pick(st_reg.wmask, 1'b0);
      tie_pkg::OFF_MASK_HI: rd_val = pick(st_reg.wmask, 1'b1);
      tie_pkg::OFF_PC_LO:   rd_val = pick(st_reg.saved_pc, 1'b0);
      tie_pkg::OFF_PC_HI:   rd_val = pick(st_reg.saved_pc, 1'b1);
      tie_pkg::OFF_HALT:    rd_val = {30'h0, st_reg.halt};
      tie_pkg::OFF_PENDING: rd_val = {26'h0, i_irq.ipi, i_irq.clock, i_irq.mchk,
                                      i_irq.dev, i_irq.perf, i_irq.mchk_busy};
      tie_pkg::OFF_CMD:     rd_val = 32'h0000_0000;
      default:              rd_ok  = 1'b0;
    endcase
    wr_ok = (st_reg.aw_addr == tie_pkg::OFF_CMD) || (st_reg.aw_addr == tie_pkg::OFF_SUMMARY);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.entry_valid = 1'b0;
    // write channel capture
    if (s_axi_awvalid && !st_reg.aw_got) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata;
      // strobe travels with its data; the master may drop it once w is taken
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
    if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
    if (rd_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_ok ? rd_val : 32'h0000_0000;
      st_next.rresp  = rd_ok ? 2'b00 : 2'b10;
    end
    // software commands: trap return, syscall return, level swap
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_ok ? 2'b00 : 2'b10;
      if (st_reg.aw_addr == tie_pkg::OFF_CMD && st_reg.w_lane0) begin
        unique case (st_reg.w_data[1:0])
          tie_pkg::CMD_RET_TRAP,
          tie_pkg::CMD_RET_SYS:  st_next.sw = legal_sw(st_reg.saved_sw);
          tie_pkg::CMD_SWAP_LVL: begin
            // lowering the level re-opens arbitration next cycle
            if (!st_reg.sw[tie_pkg::SW_MODE_BIT])
              st_next.sw = {tie_pkg::MODE_KERNEL, st_reg.w_data[6:4]};
          end
          default: ;
        endcase
      end else if (st_reg.aw_addr == tie_pkg::OFF_SUMMARY && st_reg.w_lane0) begin
        // writing clears summary and write mask
        st_next.summary = 7'h00;
        st_next.wmask   = 64'h0;
      end
    end
    // pipeline reports of exceptional results accumulate; set beats clear
    if (i_fault.arith) begin
      st_next.summary = st_next.summary | (i_fault.arith_flags & 7'h7E);
      st_next.wmask[{i_fault.dest_fp, i_fault.dest_reg}] = 1'b1;
    end
    // entry dispatch, one at a time, kernel stack halt has top priority, double mchk halt only after all faults
    if (st_reg.halt == tie_pkg::HALT_NONE) begin
      if (i_fault.stack_fault || (i_fault.ksp[2:0] != 3'h0)) begin
        st_next.halt  = tie_pkg::HALT_KSTK;
        st_next.entry = tie_pkg::ENT_HALT;
      end else if (i_fault.arith || i_fault.instr || i_fault.mem
                   || i_fault.una || i_fault.sys || irq_go) begin
        st_next.entry_valid = 1'b1;
        st_next.saved_sw    = st_reg.sw;
        st_next.saved_pc    = i_fault.pc;
        st_next.sw[tie_pkg::SW_MODE_BIT] = tie_pkg::MODE_KERNEL;
        if (i_fault.arith) begin
          st_next.entry = tie_pkg::ENT_ARITH;
          st_next.a0 = {57'h0, st_next.summary};
          st_next.a1 = st_next.wmask;
          st_next.saved_pc = i_fault.pc;
        end else if (i_fault.instr) begin
          st_next.entry = tie_pkg::ENT_INSTR;
          st_next.a0 = {61'h0, i_fault.instr_code};
          st_next.saved_pc = (i_fault.instr_code == 3'h3) ? i_fault.pc
                             : i_fault.pc + 64'h4;
        end else if (i_fault.mem) begin
          st_next.entry = tie_pkg::ENT_MEM;
          st_next.a0 = i_fault.vaddr;
          st_next.a1 = {61'h0, i_fault.mem_code};
          st_next.a2 = (i_fault.mem_kind == 2'h2) ? 64'hFFFF_FFFF_FFFF_FFFF
                     : (i_fault.mem_kind == 2'h1) ? 64'h1 : 64'h0;
          st_next.sw = {tie_pkg::MODE_KERNEL, st_reg.sw[2:0]};
        end else if (i_fault.una) begin
          st_next.entry = tie_pkg::ENT_UNA;
          st_next.a0 = i_fault.vaddr;
          st_next.a1 = {58'h0, i_fault.una_instr[31:26]};
          st_next.a2 = {59'h0, i_fault.una_instr[25:21]};
          st_next.sw = {tie_pkg::MODE_KERNEL, st_reg.sw[2:0]};
        end else if (i_fault.sys) begin
          // a0..a2 keep their contents; only scratch state is touched
          st_next.entry = tie_pkg::ENT_SYS;
          st_next.saved_pc = i_fault.pc + 64'h4;
          st_next.sw = {tie_pkg::MODE_KERNEL, st_reg.sw[2:0]};
        end else if (irq_code == 3'h2 && i_irq.mchk_busy) begin
          st_next.entry_valid = 1'b0;
          st_next.halt  = tie_pkg::HALT_DMCHK;
          st_next.entry = tie_pkg::ENT_HALT;
          st_next.sw    = st_reg.sw;
        end else begin
          st_next.entry = tie_pkg::ENT_INTR;
          st_next.sw = {tie_pkg::MODE_KERNEL, irq_lvl};
          st_next.a0 = {61'h0, irq_code};
          st_next.a1 = i_irq.vector;
          st_next.a2 = (irq_code == 3'h2) ? i_irq.logout_addr : 64'h0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_reg       <= '0;
      st_reg.sw    <= tie_pkg::SW_RESET;
      st_reg.entry <= tie_pkg::ENT_NONE;
      st_reg.halt  <= tie_pkg::HALT_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_entry_valid = st_reg.entry_valid;
  assign o_entry       = st_reg.entry;
  assign o_status_word = st_reg.sw;
  assign o_halt        = st_reg.halt != tie_pkg::HALT_NONE;
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready  = !st_reg.w_got;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_user_zero;
    @(posedge i_clk) disable iff (!i_resetn)
      o_status_word[3] |-> o_status_word[2:0] == 3'h0;
  endproperty
  a_user_zero: assert property (p_user_zero) else $error("user mode with level");

  property p_entry_kernel;
    @(posedge i_clk) disable iff (!i_resetn)
      o_entry_valid |-> !o_status_word[3];
  endproperty
  a_entry_kernel: assert property (p_entry_kernel) else $error("entry not kernel");

  property p_sw_stable;
    @(posedge i_clk) disable iff (!i_resetn)
      (!o_entry_valid && !$past(wr_fire)) |-> $stable(o_status_word);
  endproperty
  a_sw_stable: assert property (p_sw_stable) else $error("status word changed");

  property p_mchk_lvl;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_entry_valid && o_entry == tie_pkg::ENT_INTR && st_reg.a0 == 64'h2)
        |-> o_status_word[2:0] == 3'h7;
  endproperty
  a_mchk_lvl: assert property (p_mchk_lvl) else $error("mchk level wrong");

  property p_int_above;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_entry_valid && o_entry == tie_pkg::ENT_INTR)
        |-> o_status_word[2:0] > $past(o_status_word[2:0]);
  endproperty
  a_int_above: assert property (p_int_above) else $error("interrupt not above level");

  property p_arith_keep;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_entry_valid && o_entry == tie_pkg::ENT_ARITH)
        |-> o_status_word[2:0] == $past(o_status_word[2:0]);
  endproperty
  a_arith_keep: assert property (p_arith_keep) else $error("arith changed level");

  property p_dmchk;
    @(posedge i_clk) disable iff (!i_resetn)
      (irq_go && irq_code == 3'h2 && i_irq.mchk_busy && !o_halt
       && !i_fault.arith && !i_fault.instr && !i_fault.mem && !i_fault.una
       && !i_fault.sys && !i_fault.stack_fault && i_fault.ksp[2:0] == 3'h0)
        |=> o_halt && !o_entry_valid;
  endproperty
  a_dmchk: assert property (p_dmchk) else $error("no double mchk halt");

  property p_kstk;
    @(posedge i_clk) disable iff (!i_resetn)
      (!o_halt && i_fault.ksp[2:0] != 3'h0) |=> o_halt;
  endproperty
  a_kstk: assert property (p_kstk) else $error("no stack halt");

  property p_mem_a2;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_entry_valid && o_entry == tie_pkg::ENT_MEM && $past(i_fault.mem_kind) == 2'h1)
        |-> st_reg.a2 == 64'h1;
  endproperty
  a_mem_a2: assert property (p_mem_a2) else $error("store a2 wrong");

  property p_mem_fetch;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_entry_valid && o_entry == tie_pkg::ENT_MEM && $past(i_fault.mem_kind) == 2'h2)
        |-> st_reg.a2 == 64'hFFFF_FFFF_FFFF_FFFF;
  endproperty
  a_mem_fetch: assert property (p_mem_fetch) else $error("fetch a2 wrong");

  property p_halt_sticky;
    @(posedge i_clk) disable iff (!i_resetn)
      o_halt |=> o_halt && !o_entry_valid;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt released");

  property p_instr_keep;
    @(posedge i_clk) disable iff (!i_resetn)
      (o_entry_valid && o_entry == tie_pkg::ENT_INSTR)
        |-> o_status_word[2:0] == $past(o_status_word[2:0]);
  endproperty
  a_instr_keep: assert property (p_instr_keep) else $error("instr fault changed level");
endmodule : tie_core

// ==== sim/tie_irq_model.sv ====
// interrupt source and handler model facing the trap entry block
`timescale 1ns/1ps
module tie_irq_model #(
  parameter logic [63:0] VECTOR = 64'h0000_0000_0000_0800,
  parameter logic [63:0] LOGOUT = 64'h0000_0000_0000_4000
) (
  input  wire logic         i_clk,
  input  wire logic [4:0]   i_req,
  input  wire logic         i_busy,
  output tie_pkg::tie_irq_t o_irq
);
  // ---------------------------------------------------------------
  // request levels held until the handler drops them
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    o_irq.ipi         <= i_req[0];
    o_irq.clock       <= i_req[1];
    o_irq.mchk        <= i_req[2];
    o_irq.dev         <= i_req[3];
    o_irq.dev_level   <= 3'h3;
    o_irq.perf        <= i_req[4];
    o_irq.vector      <= VECTOR;
    o_irq.logout_addr <= LOGOUT;
    o_irq.mchk_busy   <= i_busy;
  end
endmodule : tie_irq_model

// ==== sim/tb_top.sv ====
// self-checking bench for the trap and interrupt entry block
`timescale 1ns/1ps
module tb_top;
  logic                i_clk, i_resetn = 1'b0, ent_v, halt, awr, wrdy, bv, arr, rv;
  logic                awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, busy = 1'b0;
  logic [7:0]          awa = 8'h00, ara = 8'h00;
  logic [31:0]         wd = 32'h0, rdat;
  logic [1:0]          bresp, rresp;
  logic [3:0]          sw;
  logic [4:0]          req = 5'h00;
  tie_pkg::tie_fault_t flt = '0;
  tie_pkg::tie_irq_t   irq;
  tie_pkg::tie_entry_t ent;
  int                  fail_count, num_checks;

  tie_core dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_fault(flt), .i_irq(irq),
    .o_entry_valid(ent_v), .o_entry(ent), .o_status_word(sw), .o_halt(halt),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp));
  tie_irq_model src (.i_clk(i_clk), .i_req(req), .i_busy(busy), .o_irq(irq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    br  <= 1'b1;
    r = 2'h3;
    forever begin
      @(posedge i_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) begin
        r = bresp;
        break;
      end
    end
    br <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    arv <= 1'b1;
    ara <= a;
    rr  <= 1'b1;
    d = '1;
    r = 2'h3;
    forever begin
      @(posedge i_clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        d = rdat;
        r = rresp;
        break;
      end
    end
    rr <= 1'b0;
  endtask : axi_rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, e);
  endtask : rchk

  // a chosen level can only be written through the level swap command
  task automatic swap(input logic [2:0] l);
    logic [1:0] r;
    axi_wr(tie_pkg::OFF_CMD, {25'h0, l, 2'h0, tie_pkg::CMD_SWAP_LVL}, r);
    chk(r, 2'h0);
  endtask : swap

  task automatic fire(input tie_pkg::tie_fault_t f, input tie_pkg::tie_entry_t e);
    @(posedge i_clk);
    flt <= f;
    @(posedge i_clk);
    flt <= '0;
    #1;
    for (int n = 0; n < 20 && ent_v !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk(ent_v, 1'b1);
    chk(ent, e);
  endtask : fire

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_irq;
    logic [2:0] lv [5] = '{tie_pkg::LVL_IPI, tie_pkg::LVL_CLOCK, tie_pkg::LVL_MCHK, 3'h3,
                           tie_pkg::LVL_PERF};
    int         ord [5] = '{1, 0, 3, 4, 2};
    int         seen = 0;
    logic [1:0] r;
    chk(sw, tie_pkg::SW_RESET);
    rchk(tie_pkg::OFF_STATUS, 32'(tie_pkg::SW_RESET));
    req <= 5'h02;
    repeat (10) begin
      @(posedge i_clk);
      #1;
      if (ent_v === 1'b1) seen++;
    end
    chk(seen, 0);
    req <= 5'h00;
    foreach (ord[k]) begin
      swap(3'h0);
      chk(sw, 4'h0);
      req <= 5'(1 << ord[k]);
      for (int n = 0; n < 20 && sw !== {1'b0, lv[ord[k]]}; n++) @(posedge i_clk);
      #1;
      chk(sw, {1'b0, lv[ord[k]]});
      rchk(tie_pkg::OFF_ENTRY, 32'(tie_pkg::ENT_INTR));
      rchk(tie_pkg::OFF_ARG0_LO, ord[k]);
      if (ord[k] > 1) rchk(tie_pkg::OFF_ARG1_LO, 32'h800);
      if (ord[k] == 2) rchk(tie_pkg::OFF_ARG2_LO, 32'h4000);
      req <= 5'h00;
    end
    // trap return brings back the level saved at the last entry
    axi_wr(tie_pkg::OFF_CMD, 32'(tie_pkg::CMD_RET_TRAP), r);
    chk(r, 2'h0);
    chk(sw, 4'h0);
    $display("t_irq done");
  endtask : t_irq

  task automatic t_arith;
    tie_pkg::tie_fault_t f = '0;
    logic [3:0]          s0;
    s0 = sw;
    f.arith = 1'b1;
    f.arith_flags = 7'(1 << tie_pkg::BIT_IOV);
    f.dest_fp = 1'b1;
    f.dest_reg = 5'h03;
    f.pc = 64'h1000;
    fire(f, tie_pkg::ENT_ARITH);
    chk(sw, s0);
    rchk(tie_pkg::OFF_SUMMARY, 32'(1 << tie_pkg::BIT_IOV));
    rchk(tie_pkg::OFF_MASK_LO, 32'h0);
    rchk(tie_pkg::OFF_MASK_HI, 32'h8);
    rchk(tie_pkg::OFF_PC_LO, 32'h1000);
    $display("t_arith done");
  endtask : t_arith

  task automatic t_faults;
    tie_pkg::tie_fault_t f;
    logic [31:0]         a2 [3] = '{32'h0, 32'h1, 32'hFFFF_FFFF};
    logic [31:0]         u = 32'hA4E0_0000;
    for (int c = 0; c < 5; c++) begin
      f = '0;
      f.instr = 1'b1;
      f.instr_code = 3'(c);
      f.pc = 64'h2000;
      fire(f, tie_pkg::ENT_INSTR);
      rchk(tie_pkg::OFF_ARG0_LO, c);
      rchk(tie_pkg::OFF_PC_LO, c == 3 ? 32'h2000 : 32'h2004);
      f = '0;
      f.mem = 1'b1;
      f.mem_code = 3'(c);
      f.mem_kind = 2'(c % 3);
      f.vaddr = 64'h8000;
      fire(f, tie_pkg::ENT_MEM);
      rchk(tie_pkg::OFF_ARG0_LO, 32'h8000);
      rchk(tie_pkg::OFF_ARG1_LO, c);
      rchk(tie_pkg::OFF_ARG2_LO, a2[c % 3]);
    end
    f = '0;
    f.una = 1'b1;
    f.una_instr = u;
    f.vaddr = 64'h9003;
    fire(f, tie_pkg::ENT_UNA);
    rchk(tie_pkg::OFF_ARG1_LO, {26'h0, u[31:26]});
    rchk(tie_pkg::OFF_ARG2_LO, {27'h0, u[25:21]});
    rchk(tie_pkg::OFF_ARG0_LO, 32'h9003);
    f = '0;
    f.sys = 1'b1;
    f.pc = 64'h3000;
    fire(f, tie_pkg::ENT_SYS);
    rchk(tie_pkg::OFF_PC_LO, 32'h3004);
    rchk(tie_pkg::OFF_ARG0_LO, 32'h9003);
    $display("t_faults done");
  endtask : t_faults

  task automatic t_halt;
    logic [1:0]  r;
    logic [31:0] d;
    logic [3:0]  s0;
    s0 = sw;
    axi_wr(tie_pkg::OFF_STATUS, 32'h0, r);
    chk(r, 2'h2);
    chk(sw, s0);
    axi_rd(8'h40, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    busy <= 1'b1;
    swap(3'h0);
    req <= 5'h04;
    for (int n = 0; n < 20 && halt !== 1'b1; n++) @(posedge i_clk);
    #1;
    chk(halt, 1'b1);
    rchk(tie_pkg::OFF_HALT, 32'(tie_pkg::HALT_DMCHK));
    $display("t_halt done");
  endtask : t_halt

  // a second reset clears the sticky halt, then a misaligned stack halts again
  task automatic t_kstk;
    tie_pkg::tie_fault_t f;
    f = '0;
    f.ksp = 64'h4;
    req <= 5'h00;
    busy <= 1'b0;
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(halt, 1'b0);
    chk(sw, tie_pkg::SW_RESET);
    @(posedge i_clk);
    flt <= f;
    @(posedge i_clk);
    flt <= '0;
    #1;
    chk(halt, 1'b1);
    chk(ent, tie_pkg::ENT_HALT);
    rchk(tie_pkg::OFF_HALT, 32'(tie_pkg::HALT_KSTK));
    $display("t_kstk done");
  endtask : t_kstk

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    #1;
    t_irq();
    t_arith();
    t_faults();
    t_halt();
    t_kstk();
    close_out();
  end
endmodule : tb_top
